/* rtl/tar_pkg.sv */
// Package of constants and types for the trip, alarm and reset logic
package tar_pkg;

  // ==========================================================
  // Register map (byte addresses, 32-bit words)
  localparam logic [7:0] CFG_ADDR = 8'h00;
  localparam logic [7:0] TCA_ADDR = 8'h04;
  localparam logic [7:0] TRIP_ADDR = 8'h08;
  localparam logic [7:0] ALARM_ADDR = 8'h0C;
  localparam logic [7:0] TCU_ADDR = 8'h10;

  // ==========================================================
  // Configuration field positions
  localparam int CFG_OL_AUTO = 0;
  localparam int CFG_KEY_LOCK = 1;
  localparam int CFG_UNB_EN = 2;
  localparam int CFG_OCC_EN = 3;
  localparam int CFG_KEY_ALM = 4;
  localparam int CFG_TCA_AUX = 5;
  localparam logic [5:0] CFG_RESET = 6'h16;
  localparam logic [6:0] TCA_OFF = 7'h00;
  localparam logic [6:0] TCA_MAX = 7'h64;

  // ==========================================================
  // Thresholds and timing
  localparam logic [6:0] OL_RESET_PCT = 7'h0F;
  localparam logic [6:0] UNB_PCT = 7'h0F;
  localparam int CLK_MHZ = 200;
  localparam int UNB_TIME_S = 5;
  localparam longint UNB_CYCLES = longint'(UNB_TIME_S) * CLK_MHZ * 1000000;
  localparam int OCC_TIME_MS = 500;
  localparam longint OCC_CYCLES = longint'(OCC_TIME_MS) * CLK_MHZ * 1000;

  // ==========================================================
  // Trip and alarm bit positions
  localparam int TRIP_OL = 0;
  localparam int TRIP_GF = 1;
  localparam int TRIP_LR = 2;
  localparam int TRIP_OCC = 3;
  localparam int ALM_UNB = 0;
  localparam int ALM_TCA = 1;
  localparam int ALM_ACC = 2;
  localparam int ALM_GRS = 3;
  localparam int ALM_INSP = 4;
  localparam int ALM_STOP = 5;

  typedef enum logic [1:0] {
    OCC_IDLE = 2'b00,
    OCC_WAIT = 2'b01,
    OCC_DONE = 2'b10
  } tar_occ_t;

  typedef struct packed {
    logic resetKey;
    logic lockoutIn;
    logic lockoutCfg;
    logic startCmd;
    logic contactorClosed;
  } tar_pins_t;

endpackage

/* rtl/tar_persist.sv */
// Persistence timer: output rises once input held high for a count
`timescale 1ns/100ps
module tar_persist #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] COUNT = '1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic cond,
  output logic held
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic held;
  } tar_pst_t;

  tar_pst_t state_q, state_d;

  always_comb begin
    state_d = state_q;
    if (!cond) begin
      state_d.cnt = '0;
      state_d.held = 1'b0;
    end else if (state_q.cnt < COUNT) begin
      state_d.cnt = state_q.cnt + 1'b1;
    end else begin
      state_d.held = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign held = state_q.held;
endmodule

/* rtl/tar_trip_alarm.sv */
// Trip latching, alarm generation and reset logic for a motor relay
//
// What this block does
// [RULE1] In automatic mode an overload trip clears itself once TCU < 15%.
// [RULE2] In manual mode a key press clears the overload trip at TCU < 15%.
// [RULE3] Key lockout clearing on: the key clears trips whose cause is gone.
// [RULE4] Key lockout clearing off: the key cannot clear the lockout trips.
// [RULE5] Key lockout clearing off: only the lockout input clears those trips.
// [RULE6] A programmed lockout-reset input takes lockout trips from the key.
// [RULE7] Unbalance alarm only after unbalance > 15% held for 5 seconds.
// [RULE8] Thermal capacity alarm when TCU exceeds a 1..100 level; 0 is off.
// [RULE9] The thermal capacity alarm may be routed to a dedicated aux relay.
// [RULE10] Open control circuit trip if feedback stays open after a start.
// [RULE11] With alarm key clearing on, the key clears the four latched alarms.
// [RULE12] All other alarms follow their cause and clear by themselves.
// [RULE13] Stopped-motor thermal capacity decays exponentially; done outside.
// [RULE14] Every trip stays latched until a permitted reset clears it.
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
module tar_trip_alarm #(
  parameter longint UNB_CNT = tar_pkg::UNB_CYCLES,
  parameter longint OCC_CNT = tar_pkg::OCC_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire tar_pkg::tar_pins_t pins,
  input wire logic [6:0] tcUsed,
  input wire logic [6:0] unbalancePct,
  input wire logic olCond,
  input wire logic gfCond,
  input wire logic lrCond,
  input wire logic [3:0] keyAlarmCond,
  output logic [3:0] trips,
  output logic [5:0] alarms,
  output logic tcAuxRelay
);
  import tar_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    tar_pins_t sync1;
    tar_pins_t sync2;
    logic keyPrev;
    logic lockPrev;
    logic startPrev;
    logic [5:0] cfg;
    logic [6:0] tcaLevel;
    logic [3:0] trip;
    logic [5:0] alarm;
    logic auxRelay;
    logic [39:0] unbRun;
    tar_occ_t occ;
    logic [39:0] occCnt;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [1:0] bResp;
  } tar_state_t;

  tar_state_t state_q, state_d;
  logic unbHeld;
  logic keyPress, lockPress, startEdge;
  logic lockoutByKey, lockoutByInput;
  logic [3:0] tripClr;
  logic tcLow, occCond, tcaHit;
  logic doWrite, doRead;
  logic [31:0] rdWord;

  // ==========================================================
  // Unbalance persistence
  // [RULE7] 15% for 5 s
  tar_persist #(
    .WIDTH(40),
    .COUNT(40'(UNB_CNT))
  ) unbTimer (
    .clk(clk),
    .srst(srst),
    .cond(state_q.cfg[CFG_UNB_EN] && (unbalancePct > UNB_PCT)),
    .held(unbHeld)
  );

  // ==========================================================
  // Decisions
  always_comb begin
    keyPress = state_q.sync2.resetKey && !state_q.keyPrev;
    lockPress = state_q.sync2.lockoutIn && !state_q.lockPrev;
    startEdge = state_q.sync2.startCmd && !state_q.startPrev;
    tcLow = tcUsed < OL_RESET_PCT;
    // [RULE4] [RULE6] key authority over lockout trips
    lockoutByKey = state_q.cfg[CFG_KEY_LOCK] && !state_q.sync2.lockoutCfg;
    // [RULE5] input authority over lockout trips
    lockoutByInput = state_q.sync2.lockoutCfg || !state_q.cfg[CFG_KEY_LOCK];
    tripClr = '0;
    // [RULE1] [RULE2] overload reset gated by cooling
    if (tcLow && !olCond) begin
      if (state_q.cfg[CFG_OL_AUTO]) begin
        tripClr[TRIP_OL] = 1'b1;
      end else if ((keyPress && lockoutByKey)
                   || (lockPress && lockoutByInput)) begin
        tripClr[TRIP_OL] = 1'b1;
      end
    end
    // [RULE3] key clears only trips whose cause is gone
    if ((keyPress && lockoutByKey) || (lockPress && lockoutByInput)) begin
      tripClr[TRIP_GF] = !gfCond;
      tripClr[TRIP_LR] = !lrCond;
    end
    if (keyPress) begin
      tripClr[TRIP_OCC] = state_q.occ != OCC_DONE;
    end
    occCond = state_q.occ == OCC_DONE;
    // [RULE8] level 0 is off
    tcaHit = (state_q.tcaLevel != TCA_OFF) && (tcUsed > state_q.tcaLevel);
  end

  // ==========================================================
  // Bus decode
  always_comb begin
    doWrite = state_q.awHeld && state_q.wHeld && !state_q.bValid;
    doRead = s_axi_arvalid && !state_q.rValid;
    case (s_axi_araddr[7:0])
      CFG_ADDR: rdWord = {26'h0, state_q.cfg};
      TCA_ADDR: rdWord = {25'h0, state_q.tcaLevel};
      TRIP_ADDR: rdWord = {28'h0, state_q.trip};
      ALARM_ADDR: rdWord = {26'h0, state_q.alarm};
      TCU_ADDR: rdWord = {25'h0, tcUsed};
      default: rdWord = 32'h0000_0000;
    endcase
  end

  always_comb begin
    state_d = state_q;
    state_d.sync1 = pins;
    state_d.sync2 = state_q.sync1;
    state_d.keyPrev = state_q.sync2.resetKey;
    state_d.lockPrev = state_q.sync2.lockoutIn;
    state_d.startPrev = state_q.sync2.startCmd;

    // [RULE10] wait for contactor feedback after a start
    state_d.occCnt = '0;
    case (state_q.occ)
      OCC_IDLE: begin
        if (startEdge && state_q.cfg[CFG_OCC_EN]) begin
          state_d.occ = OCC_WAIT;
        end
      end
      OCC_WAIT: begin
        if (state_q.sync2.contactorClosed || !state_q.cfg[CFG_OCC_EN]) begin
          state_d.occ = OCC_IDLE;
        end else if (state_q.occCnt >= 40'(OCC_CNT)) begin
          state_d.occ = OCC_DONE;
        end else begin
          state_d.occCnt = state_q.occCnt + 40'h1;
        end
      end
      OCC_DONE: begin
        if (state_q.sync2.contactorClosed || !state_q.sync2.startCmd) begin
          state_d.occ = OCC_IDLE;
        end
      end
      default: state_d.occ = OCC_IDLE;
    endcase

    // [RULE14] trips hold until cleared; set wins over clear
    state_d.trip = (state_q.trip & ~tripClr)
                   | {occCond, lrCond, gfCond, olCond};

    // [RULE12] self-clearing alarms follow their cause
    state_d.alarm[ALM_UNB] = unbHeld;
    state_d.alarm[ALM_TCA] = tcaHit;
    // [RULE9] aux relay routing
    state_d.auxRelay = tcaHit && state_q.cfg[CFG_TCA_AUX];
    // Checker-only run length of unbalance, saturating past the limit
    if (!(state_q.cfg[CFG_UNB_EN] && (unbalancePct > UNB_PCT))) begin
      state_d.unbRun = '0;
    end else if (state_q.unbRun <= 40'(UNB_CNT)) begin
      state_d.unbRun = state_q.unbRun + 40'h1;
    end
    // [RULE11] key-clearable alarms latch
    if (keyPress && state_q.cfg[CFG_KEY_ALM]) begin
      state_d.alarm[5:2] = keyAlarmCond;
    end else begin
      state_d.alarm[5:2] = state_q.alarm[5:2] | keyAlarmCond;
    end

    // Bus write path, address and data accepted in either order
    if (s_axi_awvalid && !state_q.awHeld) begin
      state_d.awHeld = 1'b1;
      state_d.awAddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !state_q.wHeld) begin
      state_d.wHeld = 1'b1;
      state_d.wData = s_axi_wdata;
      state_d.wStrb = s_axi_wstrb;
    end
    if (doWrite) begin
      state_d.awHeld = 1'b0;
      state_d.wHeld = 1'b0;
      state_d.bValid = 1'b1;
      state_d.bResp = 2'b00;
      case (state_q.awAddr)
        CFG_ADDR: begin
          if (state_q.wStrb[0]) begin
            state_d.cfg = state_q.wData[5:0];
          end
        end
        TCA_ADDR: begin
          // Out of range levels are refused so the alarm cannot go stuck
          if (state_q.wStrb[0] && state_q.wData[6:0] <= TCA_MAX) begin
            state_d.tcaLevel = state_q.wData[6:0];
          end
        end
        TRIP_ADDR, ALARM_ADDR, TCU_ADDR: state_d.bResp = 2'b00;
        default: state_d.bResp = 2'b10;
      endcase
    end
    if (state_q.bValid && s_axi_bready) begin
      state_d.bValid = 1'b0;
    end
    if (doRead) begin
      state_d.rValid = 1'b1;
      state_d.rData = rdWord;
      state_d.rResp = (s_axi_araddr[7:0] > TCU_ADDR
                       || s_axi_araddr[1:0] != 2'b00) ? 2'b10 : 2'b00;
    end else if (state_q.rValid && s_axi_rready) begin
      state_d.rValid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= '0;
      state_q.cfg <= CFG_RESET;
      state_q.occ <= OCC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = !state_q.awHeld;
  assign s_axi_wready = !state_q.wHeld;
  assign s_axi_bvalid = state_q.bValid;
  assign s_axi_bresp = state_q.bResp;
  assign s_axi_arready = !state_q.rValid;
  assign s_axi_rvalid = state_q.rValid;
  assign s_axi_rdata = state_q.rData;
  assign s_axi_rresp = state_q.rResp;
  assign trips = state_q.trip;
  assign alarms = state_q.alarm;
  assign tcAuxRelay = state_q.auxRelay;

  // ==========================================================
  // Checks
  ol_auto_a: assert property (@(posedge clk) disable iff (srst) // [RULE1]
    state_q.cfg[CFG_OL_AUTO] && state_q.trip[TRIP_OL] && tcLow && !olCond
    |=> !trips[TRIP_OL])
    else $error("overload not auto cleared");
  ol_hold_a: assert property (@(posedge clk) disable iff (srst) // [RULE2]
    trips[TRIP_OL] && !tcLow |=> trips[TRIP_OL])
    else $error("overload cleared while hot");
  key_clear_a: assert property (@(posedge clk) disable iff (srst) // [RULE3]
    keyPress && lockoutByKey && trips[TRIP_GF] && !gfCond
    |=> !trips[TRIP_GF])
    else $error("ground fault not cleared by key");
  key_lock_a: assert property (@(posedge clk) disable iff (srst) // [RULE4]
    !state_q.cfg[CFG_KEY_LOCK] && !lockPress && trips[TRIP_LR]
    |=> trips[TRIP_LR])
    else $error("locked rotor cleared without input");
  input_clr_a: assert property (@(posedge clk) disable iff (srst) // [RULE5]
    lockPress && lockoutByInput && trips[TRIP_LR] && !lrCond
    |=> !trips[TRIP_LR])
    else $error("lockout input failed to clear");
  input_cfg_a: assert property (@(posedge clk) disable iff (srst) // [RULE6]
    state_q.sync2.lockoutCfg && !lockPress && trips[TRIP_GF]
    |=> trips[TRIP_GF])
    else $error("key cleared lockout trip");
  unb_persist_a: assert property (@(posedge clk) disable iff (srst) // [RULE7]
    $rose(alarms[ALM_UNB]) |-> $past(state_q.unbRun) > 40'(UNB_CNT))
    else $error("unbalance alarm too early");
  tca_level_a: assert property (@(posedge clk) disable iff (srst) // [RULE8]
    alarms[ALM_TCA] |-> $past(state_q.tcaLevel != TCA_OFF
                              && tcUsed > state_q.tcaLevel))
    else $error("thermal alarm without cause");
  occ_trip_a: assert property (@(posedge clk) disable iff (srst) // [RULE10]
    state_q.occ == OCC_DONE |=> trips[TRIP_OCC])
    else $error("open control trip missing");
  trip_latch_a: assert property (@(posedge clk) disable iff (srst) // [RULE14]
    trips[TRIP_GF] && !keyPress && !lockPress |=> trips[TRIP_GF])
    else $error("ground fault trip dropped");
endmodule

/* tb/tar_field_model.sv */
// Field side model: reset key, interlock input and contactor contacts
`timescale 1ns/100ps
module tar_field_model (
  input wire logic clk,
  input wire logic keyReq,
  input wire logic lockReq,
  input wire logic lockCfg,
  input wire logic startReq,
  input wire logic closedReq,
  output tar_pkg::tar_pins_t pins
);
  import tar_pkg::*;
  logic [3:0] keyCnt = '0;
  logic [3:0] lockCnt = '0;
  // ====================
  // Presses
  // A press is held well past the input synchroniser
  // reset key press
  always @(posedge clk) begin
    keyCnt <= keyReq ? 4'h6 : keyCnt - {3'h0, keyCnt != 4'h0};
  end
  always @(posedge clk) begin
    lockCnt <= lockReq ? 4'h6 : lockCnt - {3'h0, lockCnt != 4'h0};
  end
  assign pins = '{resetKey: keyCnt != 4'h0, lockoutIn: lockCnt != 4'h0,
    lockoutCfg: lockCfg, startCmd: startReq, contactorClosed: closedReq};
endmodule

/* tb/trip_alarm_reset_logic_bench.sv */
// Self-checking bench for the trip, alarm and reset logic
`timescale 1ns/100ps
module trip_alarm_reset_logic_bench;
  import tar_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rdv;
  tar_pins_t pins;
  logic keyReq = 0, lockReq = 0, lockCfg = 0, startReq = 0, closedReq = 0;
  logic [6:0] tcUsed = '0, unbalancePct = '0;
  logic olCond = 0, gfCond = 0, lrCond = 0;
  logic [3:0] keyAlarmCond = '0, trips;
  logic [5:0] alarms;
  logic tcAuxRelay;
  int miscompares = 0;
  int comparisons = 0;

  tar_trip_alarm #(.UNB_CNT(20), .OCC_CNT(10)) u_tar_trip_alarm (.clk,
    .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins,
    .tcUsed, .unbalancePct, .olCond, .gfCond, .lrCond, .keyAlarmCond,
    .trips, .alarms, .tcAuxRelay);
  tar_field_model u_tar_field_model (.clk, .keyReq, .lockReq, .lockCfg,
    .startReq, .closedReq, .pins);

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ====================
  // Access and compare tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tr(input logic [3:0] e);
    chk("trips", {28'h0, trips}, {28'h0, e});
  endtask
  task automatic al(input logic [5:0] e);
    chk("alarms", {26'h0, alarms}, {26'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  // Synchroniser and edge detect need a few cycles before trips react
  task automatic key();
    keyReq <= 1'b1;
    @(posedge clk);
    keyReq <= 1'b0;
    cyc(12);
  endtask
  task automatic lock();
    lockReq <= 1'b1;
    @(posedge clk);
    lockReq <= 1'b0;
    cyc(12);
  endtask
  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ====================
  // Watchdog
  initial begin
    cyc(6000);
    miscompares++;
    complete_run();
  end

  // ====================
  // Tests
  initial begin
    cyc(12);
    srst <= 1'b0;
    cyc(1);
    rd(CFG_ADDR);
    chk("cfg", rdv, {26'h0, CFG_RESET});
    wr(8'h20, 32'h0);
    chk("wr resp", {30'h0, rs}, 32'h2);
    rd(8'h14);
    chk("rd resp", {30'h0, rs}, 32'h2);
    rd(8'h05);
    chk("misaligned resp", {30'h0, rs}, 32'h2);
    wr(TRIP_ADDR, 32'hF);
    chk("ro resp", {30'h0, rs}, 32'h0);
    rd(TRIP_ADDR);
    chk("ro trip", rdv, 32'h0);
    wr(TCA_ADDR, 32'h28);
    wr(TCA_ADDR, 32'h65);
    rd(TCA_ADDR);
    chk("level", rdv, 32'h28);
    $display("test registers done");
    wr(CFG_ADDR, 32'h20);
    tcUsed <= 7'h28;
    cyc(4);
    al(6'h00);
    tcUsed <= 7'h29;
    cyc(4);
    al(6'h02);
    chk("aux", {31'h0, tcAuxRelay}, 32'h1);
    rd(ALARM_ADDR);
    chk("alarm reg", rdv, 32'h2);
    rd(TCU_ADDR);
    chk("tcu reg", rdv, 32'h29);
    wr(CFG_ADDR, 32'h00);
    cyc(2);
    chk("aux off", {31'h0, tcAuxRelay}, 32'h0);
    al(6'h02);
    tcUsed <= 7'h10;
    cyc(4);
    al(6'h00);
    wr(TCA_ADDR, 32'h0);
    tcUsed <= 7'h64;
    cyc(4);
    al(6'h00);
    $display("test thermal alarm done");
    wr(CFG_ADDR, 32'h12);
    tcUsed <= 7'h32;
    olCond <= 1'b1;
    gfCond <= 1'b1;
    cyc(3);
    olCond <= 1'b0;
    cyc(3);
    tr(4'h3);
    rd(TRIP_ADDR);
    chk("trip reg", rdv, 32'h3);
    key();
    tr(4'h3);
    tcUsed <= 7'h0F;
    key();
    tr(4'h3);
    tcUsed <= 7'h0E;
    key();
    tr(4'h2);
    gfCond <= 1'b0;
    key();
    tr(4'h0);
    $display("test key reset done");
    wr(CFG_ADDR, 32'h10);
    lrCond <= 1'b1;
    cyc(3);
    lrCond <= 1'b0;
    key();
    tr(4'h4);
    lockCfg <= 1'b1;
    lock();
    tr(4'h0);
    wr(CFG_ADDR, 32'h12);
    gfCond <= 1'b1;
    cyc(3);
    gfCond <= 1'b0;
    key();
    tr(4'h2);
    lock();
    tr(4'h0);
    lockCfg <= 1'b0;
    $display("test lockout done");
    wr(CFG_ADDR, 32'h13);
    tcUsed <= 7'h32;
    olCond <= 1'b1;
    cyc(3);
    olCond <= 1'b0;
    cyc(20);
    tr(4'h1);
    tcUsed <= 7'h0F;
    cyc(5);
    tr(4'h1);
    tcUsed <= 7'h0E;
    cyc(5);
    tr(4'h0);
    $display("test auto reset done");
    wr(CFG_ADDR, 32'h04);
    unbalancePct <= 7'h0F;
    cyc(40);
    al(6'h00);
    unbalancePct <= 7'h10;
    cyc(15);
    unbalancePct <= 7'h00;
    cyc(2);
    unbalancePct <= 7'h10;
    cyc(15);
    al(6'h00);
    cyc(10);
    al(6'h01);
    unbalancePct <= 7'h00;
    cyc(3);
    al(6'h00);
    $display("test unbalance done");
    wr(CFG_ADDR, 32'h18);
    closedReq <= 1'b1;
    startReq <= 1'b1;
    cyc(30);
    tr(4'h0);
    startReq <= 1'b0;
    closedReq <= 1'b0;
    cyc(4);
    startReq <= 1'b1;
    cyc(8);
    tr(4'h0);
    cyc(14);
    tr(4'h8);
    startReq <= 1'b0;
    keyAlarmCond <= 4'h9;
    cyc(3);
    keyAlarmCond <= 4'h0;
    cyc(3);
    al(6'h24);
    wr(CFG_ADDR, 32'h08);
    key();
    al(6'h24);
    tr(4'h0);
    wr(CFG_ADDR, 32'h18);
    key();
    al(6'h00);
    $display("test open circuit done");
    complete_run();
  end
endmodule
